/* File: verilog/tsfr_readout.sv */
/*
 * digital frame readout of a thermal swipe sensor, 8 x 280 pixels.
 * pixel clock, reset and output enable come from a host on pins and are
 * sampled on sys_clk through three flip-flops; pixel values arrive from the
 * converter array on pix_odd / pix_even one sys_clk after pix_col/pix_pair.
 */
`timescale 1ns/1ps
`include "tsfr_map.svh"
`default_nettype none

module tsfr_readout #(
    parameter int COLUMNS     = `TSFR_COLUMNS,
    parameter int FRAME_CLKS  = `TSFR_FRAME_CLOCKS,
    parameter int PIPE_FILL   = `TSFR_PIPE_FILL
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              pclk_pin,
    input  wire logic              sensor_rst_pin,
    input  wire logic              out_en_n_pin,
    input  wire logic [3:0]        pix_odd,
    input  wire logic [3:0]        pix_even,
    input  wire logic [3:0]        thermo_code,
    input  wire logic [3:0]        info_code,
    output logic [8:0]             pix_col,
    output logic [1:0]             pix_pair,
    output logic [3:0]             odd_video_out,
    output logic [3:0]             even_video_out,
    output logic [7:0]             data_out,
    output logic [7:0]             data_oe,
    output logic                   frame_start
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [2:0] pclk_sync_q, pclk_sync_d;
    logic [2:0] rst_sync_q,  rst_sync_d;
    logic [2:0] oe_sync_q,   oe_sync_d;
    logic       pclk_lvl_q,  pclk_lvl_d;
    logic       rst_lvl_q,   rst_lvl_d;
    logic       oe_n_lvl_q,  oe_n_lvl_d;

    always_comb begin
        pclk_sync_d = {pclk_sync_q[1:0], pclk_pin};
        rst_sync_d  = {rst_sync_q[1:0], sensor_rst_pin};
        oe_sync_d   = {oe_sync_q[1:0], out_en_n_pin};
        pclk_lvl_d  = (pclk_sync_q[1] == pclk_sync_q[2]) ? pclk_sync_q[2] : pclk_lvl_q;
        rst_lvl_d   = (rst_sync_q[1] == rst_sync_q[2]) ? rst_sync_q[2] : rst_lvl_q;
        oe_n_lvl_d  = (oe_sync_q[1] == oe_sync_q[2]) ? oe_sync_q[2] : oe_n_lvl_q;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pclk_sync_q <= 3'h0;
            rst_sync_q  <= 3'h0;
            oe_sync_q   <= 3'h7;
            pclk_lvl_q  <= 1'b0;
            rst_lvl_q   <= 1'b0;
            oe_n_lvl_q  <= 1'b1;
        end else begin
            pclk_sync_q <= pclk_sync_d;
            rst_sync_q  <= rst_sync_d;
            oe_sync_q   <= oe_sync_d;
            pclk_lvl_q  <= pclk_lvl_d;
            rst_lvl_q   <= rst_lvl_d;
            oe_n_lvl_q  <= oe_n_lvl_d;
        end
    end

    logic pclk_fall;
    logic pclk_rise;
    assign pclk_fall = pclk_lvl_q & ~pclk_lvl_d;
    assign pclk_rise = ~pclk_lvl_q & pclk_lvl_d;

    // ----------------------------------------
    // sequencer: position counters
    // ----------------------------------------
    tsfr_pkg::tsfr_state_t state_q, state_d;
    logic [8:0]  col_q,   col_d;
    logic [1:0]  pair_q,  pair_d;
    logic [2:0]  fill_q,  fill_d;
    logic        taken_q, taken_d;

    always_comb begin
        state_d = state_q;
        col_d   = col_q;
        pair_d  = pair_q;
        fill_d  = fill_q;
        taken_d = taken_q;
        if (rst_lvl_q) begin
            // R1: reset pin restarts the pipeline
            state_d = tsfr_pkg::TSFR_IDLE;
            col_d   = 9'h0;
            pair_d  = 2'h0;
            fill_d  = 3'h0;
            taken_d = 1'b0;
        end else if (pclk_fall) begin
            // R6: clock taken on falling edge
            taken_d = 1'b1;
            case (state_q)
                tsfr_pkg::TSFR_IDLE: begin
                    state_d = tsfr_pkg::TSFR_FILL;
                    fill_d  = 3'h1;
                end
                tsfr_pkg::TSFR_FILL: begin
                    fill_d = fill_q + 3'h1;
                    if (fill_q == 3'(PIPE_FILL - 1)) begin
                        state_d = tsfr_pkg::TSFR_STREAM;
                    end
                end
                tsfr_pkg::TSFR_STREAM: begin
                    // R4: four bytes per column, 281 columns
                    pair_d = pair_q + 2'h1;
                    if (pair_q == 2'h3) begin
                        // R3: wrap into next frame, no reset needed
                        col_d = (col_q == 9'(COLUMNS - 1)) ? 9'h0 : col_q + 9'h1;
                    end
                end
                default: state_d = tsfr_pkg::TSFR_IDLE;
            endcase
        end else if (pclk_rise) begin
            taken_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= tsfr_pkg::TSFR_IDLE;
            col_q   <= 9'h0;
            pair_q  <= 2'h0;
            fill_q  <= 3'h0;
            taken_q <= 1'b0;
        end else begin
            state_q <= state_d;
            col_q   <= col_d;
            pair_q  <= pair_d;
            fill_q  <= fill_d;
            taken_q <= taken_d;
        end
    end

    // R12: column and row pair address to the array
    assign pix_col  = col_q;
    assign pix_pair = pair_q;

    // ----------------------------------------
    // output byte and video
    // ----------------------------------------
    tsfr_pkg::tsfr_byte_t byte_q, byte_d;
    logic [3:0] vid_odd_q, vid_odd_d;
    logic [3:0] vid_even_q, vid_even_d;
    logic       fstart_q, fstart_d;
    logic       dummy_col;

    assign dummy_col = (col_q == 9'(COLUMNS - 1));

    always_comb begin
        byte_d     = byte_q;
        fstart_d   = 1'b0;
        // R11: video tracks converter input, one clock ahead
        vid_odd_d  = pix_odd;
        vid_even_d = pix_even;
        if (rst_lvl_q) begin
            byte_d = '0;
        end else if (pclk_rise && state_q == tsfr_pkg::TSFR_STREAM) begin
            // R6: data updated on rising edge
            // R7: one two-pixel byte per clock
            byte_d.odd_pixel_nibble  = vid_odd_q;
            byte_d.even_pixel_nibble = vid_even_q;
            if (dummy_col) begin
                case (pair_q)
                    // R14: sync pattern in dummy bytes one and two
                    2'h0, 2'h1: begin
                        byte_d.odd_pixel_nibble  = `TSFR_SYNC_ODD;
                        byte_d.even_pixel_nibble = `TSFR_SYNC_EVEN;
                    end
                    // R15: thermometer in dummy byte three
                    // R16: thermometer code around 8
                    2'h2: begin
                        byte_d.odd_pixel_nibble  = info_code;
                        byte_d.even_pixel_nibble = thermo_code;
                    end
                    default: begin
                        byte_d.odd_pixel_nibble  = info_code;
                        byte_d.even_pixel_nibble = info_code;
                    end
                endcase
            end
            fstart_d = (col_q == 9'h0) && (pair_q == 2'h0);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            byte_q     <= '0;
            vid_odd_q  <= 4'h0;
            vid_even_q <= 4'h0;
            fstart_q   <= 1'b0;
        end else begin
            byte_q     <= byte_d;
            vid_odd_q  <= vid_odd_d;
            vid_even_q <= vid_even_d;
            fstart_q   <= fstart_d;
        end
    end

    assign odd_video_out  = vid_odd_q;
    assign even_video_out = vid_even_q;
    assign frame_start    = fstart_q;

    // R13: bit 3 of each nibble is the msb
    // R9: data streams always, no command path
    assign data_out = {byte_q.odd_pixel_nibble, byte_q.even_pixel_nibble};

    // R8: drive only while enable is low
    assign data_oe = {8{~oe_n_lvl_q}};

    // ----------------------------------------
    // frame period counter
    // ----------------------------------------
    localparam int POS_W = $clog2(FRAME_CLKS);
    logic [POS_W-1:0] fpos_q, fpos_d;
    logic             frame_wrap;

    assign frame_wrap = pclk_fall && state_q == tsfr_pkg::TSFR_STREAM && dummy_col && pair_q == 2'h3;

    always_comb begin
        fpos_d = fpos_q;
        if (rst_lvl_q || frame_wrap) begin
            fpos_d = '0;
        end else if (pclk_fall && state_q == tsfr_pkg::TSFR_STREAM) begin
            // R4: count clocks within one frame
            fpos_d = fpos_q + POS_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fpos_q <= '0;
        end else begin
            fpos_q <= fpos_d;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence fall_in_stream_s;
        pclk_fall && !rst_lvl_q && state_q == tsfr_pkg::TSFR_STREAM;
    endsequence

    property pair_step_p;
        @(posedge sys_clk) disable iff (!rst_n)
        fall_in_stream_s |=> pair_q == $past(pair_q) + 2'h1;
    endproperty

    pair_step_a: assert property (pair_step_p) // R4
        else $error("row pair did not advance on falling clock");

    col_wrap_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R4
        fall_in_stream_s ##0 (col_q == 9'(COLUMNS - 1) && pair_q == 2'h3) |=> col_q == 9'h0)
        else $error("frame did not wrap after last column");

    col_range_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
        col_q < 9'(COLUMNS))
        else $error("column counter out of range");

    oe_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
        oe_n_lvl_q |-> data_oe == 8'h00)
        else $error("data driven while enable high");

    sync_byte_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R14
        (pclk_rise && !rst_lvl_q && state_q == tsfr_pkg::TSFR_STREAM && dummy_col
         && (pair_q == 2'h0 || pair_q == 2'h1))
        |=> data_out == {`TSFR_SYNC_ODD, `TSFR_SYNC_EVEN})
        else $error("dummy sync byte wrong");

    thermo_byte_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R15
        (pclk_rise && !rst_lvl_q && state_q == tsfr_pkg::TSFR_STREAM && dummy_col && pair_q == 2'h2)
        |=> data_out[3:0] == $past(thermo_code))
        else $error("thermometer nibble wrong");

    hold_data_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R6
        (!pclk_rise && !rst_lvl_q) |=> $stable(data_out))
        else $error("data changed without rising clock");

    fill_done_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
        (pclk_fall && !rst_lvl_q && state_q == tsfr_pkg::TSFR_FILL && fill_q == 3'(PIPE_FILL - 1))
        |=> state_q == tsfr_pkg::TSFR_STREAM)
        else $error("stream not entered after fill clocks");

    video_lead_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
        (pclk_rise && !rst_lvl_q && state_q == tsfr_pkg::TSFR_STREAM && !dummy_col)
        |=> data_out == {$past(vid_odd_q), $past(vid_even_q)})
        else $error("digital byte not one step behind video");

    reset_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
        rst_lvl_q |=> state_q == tsfr_pkg::TSFR_IDLE && col_q == 9'h0)
        else $error("reset pin did not restart sequencer");

    frame_period_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R4
        (frame_wrap && !rst_lvl_q) |-> fpos_q == POS_W'(FRAME_CLKS - 1))
        else $error("frame length differs from frame clock count");

endmodule // tsfr_readout

`default_nettype wire

/* File: verilog/tsfr_map.svh */
/*
 * constants for the thermal swipe sensor frame readout: frame geometry,
 * dummy column patterns, pipeline depth and timing counts.
 * assumes a 25 MHz sys_clk that samples the host pins.
 */
// Overview of operation
// R1: host pulses reset, then four fill clocks
// R2: host discards the first frame
// R3: frames follow each other without reset
// R4: 281 columns, 1124 clocks per frame
// R5: host holds reset low while reading
// R6: take clock on fall, update on rise
// R7: each clock gives one two-pixel byte
// R8: data driven only while enable low
// R9: continuous stream, no command protocol
// R10: host avoids enabling in quiet interval
// R11: video leads digital nibble by one clock
// R12: upper-left first, odd/even rows split per nibble
// R13: nibble bit 3 is msb
// R14: dummy bytes one and two fixed pattern
// R15: dummy byte three even nibble is thermometer
// R16: thermometer steps 1.4 K around code 8
// R17: host treats codes 0 and 15 saturated
// R18: host heats until code rises two
// R19: host keeps frame period constant
// R20: host enters nap via reset and clock stop
// R21: host checks dummy pattern modulo 1124
`ifndef TSFR_MAP_SVH
`define TSFR_MAP_SVH

// ----------------------------------------
// frame geometry
// ----------------------------------------
`define TSFR_COLUMNS        281
`define TSFR_BYTES_PER_COL  4
`define TSFR_FRAME_CLOCKS   1124
`define TSFR_PIPE_FILL      4

// ----------------------------------------
// dummy column patterns
// ----------------------------------------
`define TSFR_SYNC_ODD       4'he
`define TSFR_SYNC_EVEN      4'h0
`define TSFR_THERMO_ZERO    4'h8

// ----------------------------------------
// timing
// ----------------------------------------
`define TSFR_CLK_PERIOD_NS  40
`define TSFR_QUIET_NS       100

`endif

/* File: verilog/tsfr_pkg.sv */
/*
 * types for the thermal swipe sensor frame readout.
 * assumes tsfr_map.svh supplies the numeric constants.
 */
`default_nettype none

package tsfr_pkg;

    typedef struct packed {
        logic [3:0] odd_pixel_nibble;
        logic [3:0] even_pixel_nibble;
    } tsfr_byte_t;

    typedef enum logic [1:0] {
        TSFR_IDLE,
        TSFR_FILL,
        TSFR_STREAM
    } tsfr_state_t;

endpackage

`default_nettype wire

/* File: verif/tsfr_host_model.sv */
/* host model for the frame readout: drives pixel clock, reset and enable pins.
   assumes sys_clk from the bench; tasks are entered just after its falling edge. */
`timescale 1ns/1ps
`default_nettype none

module tsfr_host_model (
    input  wire logic sys_clk,
    output logic      pclk_pin,
    output logic      sensor_rst_pin,
    output logic      out_en_n_pin
);
    // ----------------------------------------
    // pin sequences
    // ----------------------------------------
    // clock idles low between pulses
    initial begin
        pclk_pin = 1'b0;
        sensor_rst_pin = 1'b0;
        out_en_n_pin = 1'b0;
    end

    // every pulse 8 high, 8 low sys_clk
    task automatic pulse();
        pclk_pin = 1'b1;
        repeat (8) @(negedge sys_clk);
        pclk_pin = 1'b0;
        repeat (8) @(negedge sys_clk);
    endtask

    // reset pin stays low unless the bench restarts
    task automatic set_rst(input logic v);
        sensor_rst_pin = v;
    endtask

    // enable moves only with the clock idle, long after a fall
    task automatic set_oe_n(input logic v);
        out_en_n_pin = v;
    endtask
endmodule // tsfr_host_model

`default_nettype wire

/* File: verif/tb_tsfr_readout.sv */
/* bench for the frame readout: host model on the pins, converter model on
   the pixel bus, byte by byte comparison of the stream.
   assumes design files and host model are compiled first. */
`timescale 1ns/1ps
`default_nettype none

module tb_tsfr_readout;
    localparam int COLS = 8;
    localparam int FR   = COLS * 4;
    typedef struct packed {
        logic [3:0] thermo;
        logic [3:0] info;
        logic [7:0] byte3;
    } tsfr_row_t;

    logic       sys_clk     = 1'b0;
    logic       rst_n       = 1'b0;
    logic [3:0] pix_odd     = 4'h0;
    logic [3:0] pix_even    = 4'h0;
    logic [3:0] thermo_code = 4'h8;
    logic [3:0] info_code   = 4'h0;
    wire logic  pclk_pin;
    wire logic  sensor_rst_pin;
    wire logic  out_en_n_pin;
    logic [8:0] pix_col;
    logic [1:0] pix_pair;
    logic [3:0] odd_video_out;
    logic [3:0] even_video_out;
    logic [7:0] data_out;
    logic [7:0] data_oe;
    logic       frame_start;
    logic [7:0] dummy3;
    int         n_mismatch  = 0;
    int         checked     = 0;
    int         idx         = 0;
    int         n_first     = 0;
    int         n_fs        = 0;
    tsfr_row_t  rows [16];

    always #20 sys_clk = ~sys_clk;

    tsfr_host_model host (.sys_clk(sys_clk), .pclk_pin(pclk_pin), .sensor_rst_pin(sensor_rst_pin),
                          .out_en_n_pin(out_en_n_pin));

    tsfr_readout #(.COLUMNS(COLS), .FRAME_CLKS(FR), .PIPE_FILL(4)) uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .pclk_pin(pclk_pin), .sensor_rst_pin(sensor_rst_pin),
        .out_en_n_pin(out_en_n_pin), .pix_odd(pix_odd), .pix_even(pix_even), .thermo_code(thermo_code),
        .info_code(info_code), .pix_col(pix_col), .pix_pair(pix_pair), .odd_video_out(odd_video_out),
        .even_video_out(even_video_out), .data_out(data_out), .data_oe(data_oe), .frame_start(frame_start));

    // ----------------------------------------
    // converter model and expectations
    // ----------------------------------------
    function automatic logic [7:0] pix_of(input int i);
        return 8'(i * 37 + 5);
    endfunction

    always @(negedge sys_clk) {pix_odd, pix_even} <= pix_of(int'(pix_col) * 4 + int'(pix_pair));

    always @(posedge sys_clk) if (frame_start === 1'b1) n_fs++;

    function automatic logic [7:0] exp_byte(input int i);
        if (i < FR - 4) return pix_of(i);
        if (i % 4 == 2) return {info_code, thermo_code};
        if (i % 4 == 3) return {info_code, info_code};
        return 8'he0;
    endfunction

    // ----------------------------------------
    // checks and host sequences
    // ----------------------------------------
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic clk(input int n);
        for (int k = 0; k < n; k++) begin
            host.pulse();
            if (idx == 0) n_first++;
            if (idx == FR - 2) dummy3 = data_out;
            cmp8(data_out, exp_byte(idx));
            if (idx + 1 < FR - 4) cmp8({odd_video_out, even_video_out}, pix_of(idx + 1));
            idx = (idx + 1) % FR;
        end
    endtask

    task automatic restart();
        host.set_rst(1'b1);
        repeat (8) @(negedge sys_clk);
        cmp8(data_out, 8'h00);
        host.set_rst(1'b0);
        repeat (8) @(negedge sys_clk);
        repeat (4) host.pulse();
        idx = 0;
    endtask

    task automatic wait_oe(input logic [7:0] v);
        int k;
        for (k = 0; k < 10 && data_oe !== v; k++) @(negedge sys_clk);
        cmp8(data_oe, v);
        if (k == 10) report_and_stop();
    endtask

    task automatic report_and_stop();
        if (n_mismatch == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        restart();
        for (int k = 0; k < 16; k++) rows[k] = '{4'(k), 4'(15 - k), {4'(15 - k), 4'(k)}};
        // codes sweep through 0 to 15
        foreach (rows[k]) begin
            thermo_code = rows[k].thermo;
            info_code = rows[k].info;
            clk(FR);
            cmp8(dummy3, rows[k].byte3);
        end
        cmp8(8'(n_fs), 8'(n_first));
        host.set_oe_n(1'b1);
        wait_oe(8'h00);
        host.set_oe_n(1'b0);
        wait_oe(8'hff);
        repeat (40) @(negedge sys_clk);
        clk(FR);
        clk(5);
        restart();
        clk(FR + 2);
        rst_n = 1'b0;
        @(negedge sys_clk);
        cmp8(data_out, 8'h00);
        cmp8(data_oe, 8'h00);
        cmp8({7'h0, frame_start}, 8'h00);
        rst_n = 1'b1;
        restart();
        clk(FR + 4);
        report_and_stop();
    end
endmodule // tb_tsfr_readout

`default_nettype wire
